// ---- include/dfb_defs.svh ----
`ifndef DFB_DEFS_SVH
`define DFB_DEFS_SVH
// Notes on behaviour
// R1: dual-scan frame buffer lives in external EDO or synchronous DRAM behind the memory port.
// R2: the external DRAM holds a panel-formatted copy of the displayed frame.
// R3: formatted pixels are written to memory, then read back to refresh the panel.
// R4: timing bit 31 picks memory clock equal to pixel clock or two-thirds of it.
// R5: software clears that bit up to 800x600 and sets it for 1024x768.
// R6: control bit 4 delays EDO read-data latching by one memory clock.
// R7: control bit 3 picks rising (0) or falling (1) edge for EDO read latching.
// R8: latch delay and edge settings apply only while EDO memory is selected.
// R9: control bit 2 enables programming the synchronous DRAM mode register.
// R10: control bit 1 sends inverted (0) or non-inverted (1) clock to synchronous DRAM.
// R11: control bit 0 picks EDO (0) or synchronous DRAM (1) access protocol.
// R12: memory is used only in dual-scan modes; other panel modes leave it idle.
// R13: mode-register load happens only between accesses, then normal traffic resumes.

// ==========================================
// register map (byte addresses)
`define DFB_OFF_PTM 12'h404
`define DFB_OFF_FMC 12'h420
`define DFB_OFF_CFG 12'h424
`define DFB_OFF_STAT 12'h428
`define DFB_PTM_RST 32'h00000000
`define DFB_FMC_RST 32'h1EF80008
`define DFB_CFG_RST 32'h00000000

// ==========================================
// field positions
`define DFB_PTM_TWO_THIRDS 31
`define DFB_FMC_LATE 4
`define DFB_FMC_EDGE 3
`define DFB_FMC_MODE_LD 2
`define DFB_FMC_CLK_POL 1
`define DFB_FMC_TYPE 0
`define DFB_CFG_DUAL 0
`define DFB_STAT_MODE_PEND 0
`define DFB_STAT_BUSY 1
`define DFB_STAT_FIFO_NE 2
`define DFB_STAT_FIFO_FULL 3

// ==========================================
// timing and sizes
`define DFB_PHASE_LAST 2'h2
`define DFB_CAS_LAT 2'h2
`define DFB_FIFO_DEPTH 16
`define DFB_PIX_W 16
`define DFB_MEM_AW 18
`define DFB_FB_WORDS 18'h24000
`define DFB_MODE_WORD 18'h00020
`endif

// ---- include/dfb_fifo_if.sv ----
`timescale 1ns/100ps
interface dfb_fifo_if #(parameter int W = 16) ();
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	modport user (output push_valid, output push_data, output pop_ready,
		input push_ready, input pop_valid, input pop_data);
	modport store (input push_valid, input push_data, input pop_ready,
		output push_ready, output pop_valid, output pop_data);
endinterface

// ---- include/dfb_pkg.sv ----
package dfb_pkg;
	typedef logic [31:0] dfb_word_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_MRS = 5'h02,
		ST_WRITE = 5'h04,
		ST_READ = 5'h08,
		ST_RWAIT = 5'h10
	} dfb_state_e;
endpackage

// ---- sim/dfb_mem_model.sv ----
`timescale 1ns/100ps
// ==========
// behavioural frame buffer memory, strobes decoded on the system clock
module dfb_mem_model #(
	parameter int HOLD = 40
) (
	// clock and memory type
	input wire logic clk_i,
	input wire logic sdram_i,
	// command side
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [17:0] addr_i,
	input wire logic [15:0] d_i,
	// read data
	output logic [15:0] q_o
);
	logic [15:0] mem [int];
	logic cas_q = 1'b1;
	int hold_cnt = 0;
	int n_wr = 0;
	int n_mode = 0;
	logic [17:0] mode_addr = 18'h00000;
	initial q_o = 16'h0000;
	always @(posedge clk_i) begin
		cas_q <= cas_n_i;
		if (cas_q && !cas_n_i) begin
			if (sdram_i && !ras_n_i && !we_n_i) begin
				n_mode <= n_mode + 1;
				mode_addr <= addr_i;
			end else if (!we_n_i) begin
				mem[addr_i] = d_i;
				n_wr <= n_wr + 1;
			end else begin
				q_o <= mem.exists(addr_i) ? mem[addr_i] : 16'h5A5A;
				hold_cnt <= HOLD;
			end
		end else if (hold_cnt > 0) begin
			hold_cnt <= hold_cnt - 1;
		end else begin
			// released bus: never leave the last word standing
			q_o <= ~q_o;
		end
	end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
	import dfb_pkg::*;
	// ==========
	// signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] a = 12'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	dfb_word_t wd = 32'h00000000;
	logic [3:0] be = 4'hF;
	dfb_word_t rdata;
	logic wreq;
	logic pclk = 1'b0;
	logic prun = 1'b0;
	logic pv = 1'b0;
	logic [15:0] pd = 16'h0000;
	logic pfull, rval, mclk, ras_n, cas_n, we_n, oe;
	logic rreq = 1'b0;
	logic [15:0] rdat, dqo, mq;
	logic [17:0] maddr;
	wire logic [15:0] dqi;
	logic sdram = 1'b0;
	logic dual = 1'b0;
	logic pend = 1'b0;
	logic mprev = 1'b0;
	logic [31:0] seed = 32'hD3E7FEE3;
	logic [15:0] exq [$];
	logic [5:0] cf [6] = '{6'h04, 6'h18, 6'h01, 6'h3F, 6'h30, 6'h08};
	dfb_word_t q;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int mrise = 0;
	int emc = 0;
	int w0, r, e;
	assign dqi = oe ? dqo : mq;
	always #12.5 clk = ~clk;
	// pixel clock stands low between frames
	always #100 pclk <= prun ? ~pclk : 1'b0;
	always @(posedge clk) begin
		mprev <= mclk;
		if (mclk && !mprev)
			mrise <= mrise + 1;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails = fails + 1;
			complete_run();
		end
	end
	dfb_ctrl i_dfb_ctrl (.CLK_I(clk), .RESET_I(rst), .AV_ADDRESS_I(a), .AV_READ_I(rd), .AV_WRITE_I(wr),
		.AV_WRITEDATA_I(wd), .AV_BYTEENABLE_I(be), .AV_READDATA_O(rdata), .AV_WAITREQUEST_O(wreq),
		.PIXEL_CLOCK_I(pclk), .PIX_VALID_I(pv), .PIX_DATA_I(pd), .PIX_FULL_O(pfull), .RD_REQ_I(rreq),
		.RD_DATA_O(rdat), .RD_VALID_O(rval), .MEM_CLK_O(mclk), .MEM_RAS_N_O(ras_n), .MEM_CAS_N_O(cas_n),
		.MEM_WE_N_O(we_n), .MEM_ADDR_O(maddr), .MEM_DQ_I(dqi), .MEM_DQ_O(dqo), .MEM_DQ_OE_O(oe));
	dfb_mem_model u_mem (.clk_i(clk), .sdram_i(sdram), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
		.addr_i(maddr), .d_i(dqo), .q_o(mq));
	// ==========
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
		for (int i = 0; i < 4; i++)
			if (m[i])
				o[8*i+:8] = n[8*i+:8];
		return o;
	endfunction
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
		n_checks++;
		if (s !== x) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	// waits for the slave's answer however long it takes; only the cycle ceiling ends a hang
	task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] m);
		@(posedge clk);
		a <= ad;
		rd <= !w;
		wr <= w;
		wd <= d;
		be <= m;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic pixels(input int n);
		prun = 1'b1;
		repeat (n) begin
			@(negedge pclk);
			@(posedge clk);
			seed = lfsr(seed);
			pd <= seed[15:0];
			pv <= 1'b1;
			@(posedge pclk);
			if (dual && !pfull)
				exq.push_back(pd);
		end
		@(negedge pclk);
		@(posedge clk);
		pv <= 1'b0;
	endtask
	task automatic drain();
		int k;
		k = 0;
		do begin
			bus(1'b0, 12'h428, 32'h0, 4'hF);
			k++;
		end while (q[2] !== 1'b0 && k < 100);
		repeat (24) @(posedge clk);
		// buffer empty and no access left running
		bus(1'b0, 12'h428, 32'h0, 4'hF);
		chk("fifo_drained_idle", 32'h0, {30'h0, q[2:1]});
	endtask
	task automatic reads(input int n);
		int k;
		repeat (n) begin
			@(posedge clk);
			rreq <= 1'b1;
			@(posedge clk);
			rreq <= 1'b0;
			k = 0;
			while (rval !== 1'b1 && k < 400) begin
				@(posedge clk);
				k++;
			end
			chk("rd_valid", 32'h1, {31'h0, rval});
			chk("rd_data", {16'h0000, exq.pop_front()}, {16'h0000, rdat});
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 12'h404, 32'h0, 4'hF);
		chk("timing_reset", 32'h00000000, q);
		bus(1'b0, 12'h420, 32'h0, 4'hF);
		chk("memctl_reset", 32'h1EF80008, q);
		bus(1'b0, 12'h424, 32'h0, 4'hF);
		chk("config_reset", 32'h00000000, q);
		seed = lfsr(seed);
		bus(1'b1, 12'h404, seed, 4'h5);
		bus(1'b0, 12'h404, 32'h0, 4'hF);
		chk("timing_lanes", merge(32'h0, seed, 4'h5), q);
		bus(1'b1, 12'h100, seed, 4'hF);
		bus(1'b0, 12'h100, 32'h0, 4'hF);
		chk("unmapped", 32'h00000000, q);
		bus(1'b1, 12'h428, seed, 4'hF);
		bus(1'b0, 12'h428, 32'h0, 4'hF);
		chk("status_ro", 32'h00000000, q);
		// dual-scan off: the memory must stay untouched
		w0 = u_mem.n_wr;
		pixels(8);
		repeat (24) @(posedge clk);
		chk("writes_off", w0, u_mem.n_wr);
		bus(1'b1, 12'h424, 32'h1, 4'hF);
		dual = 1'b1;
		foreach (cf[i]) begin
			sdram = cf[i][0];
			bus(1'b1, 12'h404, {cf[i][5], 31'h0}, 4'hF);
			bus(1'b1, 12'h420, 32'h1EF80000 | {27'h0, cf[i][4:0]}, 4'hF);
			if (cf[i][2])
				pend = 1'b1;
			if (cf[i][0] && pend) begin
				emc++;
				pend = 1'b0;
			end
			r = mrise;
			e = cf[i][5] ? 8 : 12;
			pixels(12);
			r = mrise - r;
			chk("mem_clk_rate", 32'h1, {31'h0, r >= e - 1 && r <= e + 1});
			drain();
			reads(12);
			bus(1'b0, 12'h428, 32'h0, 4'hF);
			chk("mode_pending", {31'h0, pend}, {31'h0, q[0]});
			chk("mode_loads", emc, u_mem.n_mode);
			if (emc > 0)
				chk("mode_word", 32'h00000020, {14'h0, u_mem.mode_addr});
			prun = 1'b0;
			repeat (16) @(posedge clk);
			chk("mem_clk_idle", {31'h0, cf[i][0] & !cf[i][1]}, {31'h0, mclk});
		end
		// reads take every access slot, so writes starve and the buffer fills
		@(posedge clk);
		rreq <= 1'b1;
		pixels(24);
		chk("pix_full", 32'h1, {31'h0, pfull});
		bus(1'b0, 12'h428, 32'h0, 4'hF);
		chk("status_full", 32'h1, {31'h0, q[3]});
		@(posedge clk);
		rreq <= 1'b0;
		drain();
		chk("pix_full_clear", 32'h0, {31'h0, pfull});
		complete_run();
	end
endmodule

// ---- verilog/dfb_ctrl.sv ----
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "dfb_defs.svh"
module dfb_ctrl #(
	parameter int PIX_W = `DFB_PIX_W,
	parameter int MEM_AW = `DFB_MEM_AW,
	parameter logic [`DFB_MEM_AW-1:0] FB_WORDS = `DFB_FB_WORDS,
	parameter logic [`DFB_MEM_AW-1:0] MODE_WORD = `DFB_MODE_WORD
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_I,
	// avalon-mm slave
	input wire logic [11:0] AV_ADDRESS_I,
	input wire logic AV_READ_I,
	input wire logic AV_WRITE_I,
	input wire dfb_pkg::dfb_word_t AV_WRITEDATA_I,
	input wire logic [3:0] AV_BYTEENABLE_I,
	output dfb_pkg::dfb_word_t AV_READDATA_O,
	output logic AV_WAITREQUEST_O,
	// pixel port, already formatted for the panel
	input wire logic PIXEL_CLOCK_I,
	input wire logic PIX_VALID_I,
	input wire logic [PIX_W-1:0] PIX_DATA_I,
	output logic PIX_FULL_O,
	// panel refresh side
	input wire logic RD_REQ_I,
	output logic [PIX_W-1:0] RD_DATA_O,
	output logic RD_VALID_O,
	// external frame buffer memory
	output logic MEM_CLK_O,
	output logic MEM_RAS_N_O,
	output logic MEM_CAS_N_O,
	output logic MEM_WE_N_O,
	output logic [MEM_AW-1:0] MEM_ADDR_O,
	input wire logic [PIX_W-1:0] MEM_DQ_I,
	output logic [PIX_W-1:0] MEM_DQ_O,
	output logic MEM_DQ_OE_O
);
	import dfb_pkg::*;

	dfb_word_t ptm;
	dfb_word_t fmc;
	dfb_word_t cfg;
	dfb_word_t rd_word;
	dfb_state_e state;
	logic [2:0] pclk_s;
	logic [1:0] pval_s;
	logic [PIX_W-1:0] pdat_s0;
	logic [PIX_W-1:0] pdat_s1;
	logic [PIX_W-1:0] dq_s0;
	logic [PIX_W-1:0] dq_s1;
	logic [1:0] phase;
	logic [1:0] wait_cnt;
	logic [MEM_AW-1:0] wr_addr;
	logic [MEM_AW-1:0] rd_addr;
	logic pix_rise, pix_fall, mem_tick, mem_fall, mem_clk, next_mem_clk;
	logic two_thirds, sdram, late, edge_sel, clk_inv, dual_en;
	logic bus_req, bus_acc, mode_pend, rd_pend;
	logic go, issue_mrs, issue_rd, issue_wr, cap_evt, capture;

	dfb_fifo_if #(.W(PIX_W)) fifo ();

	dfb_fifo #(.W(PIX_W), .DEPTH(`DFB_FIFO_DEPTH)) u_fifo (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.f(fifo)
	);

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RESET_I);

	function automatic dfb_word_t be_merge(dfb_word_t old, dfb_word_t nw, logic [3:0] be);
		dfb_word_t r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [MEM_AW-1:0] wrap_inc(logic [MEM_AW-1:0] a);
		return (a == FB_WORDS - 1'b1) ? '0 : a + 1'b1;
	endfunction

	// ==========================================
	// register bus
	assign bus_req = AV_READ_I || AV_WRITE_I;
	assign bus_acc = bus_req && !AV_WAITREQUEST_O;
	assign two_thirds = ptm[`DFB_PTM_TWO_THIRDS];
	assign sdram = fmc[`DFB_FMC_TYPE];
	assign late = fmc[`DFB_FMC_LATE];
	assign edge_sel = fmc[`DFB_FMC_EDGE];
	assign clk_inv = sdram && !fmc[`DFB_FMC_CLK_POL];
	assign dual_en = cfg[`DFB_CFG_DUAL];

	// one wait cycle per access keeps read data a registered output
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			AV_WAITREQUEST_O <= 1'b1;
		end else begin
			AV_WAITREQUEST_O <= !(bus_req && AV_WAITREQUEST_O);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ptm <= `DFB_PTM_RST;
			fmc <= `DFB_FMC_RST;
			cfg <= `DFB_CFG_RST;
		end else if (AV_WRITE_I && bus_acc) begin
			unique case (AV_ADDRESS_I)
				`DFB_OFF_PTM: ptm <= be_merge(ptm, AV_WRITEDATA_I, AV_BYTEENABLE_I);
				`DFB_OFF_FMC: fmc <= be_merge(fmc, AV_WRITEDATA_I, AV_BYTEENABLE_I);
				`DFB_OFF_CFG: cfg <= be_merge(cfg, AV_WRITEDATA_I, AV_BYTEENABLE_I);
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_word = '0;
		unique case (AV_ADDRESS_I)
			`DFB_OFF_PTM: rd_word = ptm;
			`DFB_OFF_FMC: rd_word = fmc;
			`DFB_OFF_CFG: rd_word = {31'h00000000, dual_en};
			`DFB_OFF_STAT: begin
				rd_word[`DFB_STAT_MODE_PEND] = mode_pend;
				rd_word[`DFB_STAT_BUSY] = state != ST_IDLE;
				rd_word[`DFB_STAT_FIFO_NE] = fifo.pop_valid;
				rd_word[`DFB_STAT_FIFO_FULL] = !fifo.push_ready;
			end
			default: ;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			AV_READDATA_O <= '0;
		end else if (AV_READ_I && AV_WAITREQUEST_O) begin
			AV_READDATA_O <= rd_word;
		end
	end

	// ==========================================
	// input synchronisers
	always_ff @(posedge CLK_I) begin
		pclk_s <= {pclk_s[1:0], PIXEL_CLOCK_I};
		pval_s <= {pval_s[0], PIX_VALID_I};
		pdat_s0 <= PIX_DATA_I;
		pdat_s1 <= pdat_s0;
		dq_s0 <= MEM_DQ_I;
		dq_s1 <= dq_s0;
	end

	assign pix_rise = pclk_s[1] && !pclk_s[2];
	assign pix_fall = !pclk_s[1] && pclk_s[2];

	// ==========================================
	// memory clock: every pixel clock, or two of every three
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			phase <= '0;
		end else if (pix_rise) begin
			phase <= (phase == `DFB_PHASE_LAST) ? 2'h0 : phase + 2'h1;
		end
	end

	assign mem_tick = pix_rise && !(two_thirds && phase == `DFB_PHASE_LAST); // R4
	assign mem_fall = pix_fall && mem_clk;
	assign next_mem_clk = mem_tick ? 1'b1 : (mem_fall ? 1'b0 : mem_clk);

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			mem_clk <= 1'b0;
			MEM_CLK_O <= 1'b0;
		end else begin
			mem_clk <= next_mem_clk;
			MEM_CLK_O <= next_mem_clk ^ clk_inv; // R10
		end
	end

	// ==========================================
	// pixel intake; pixels offered while full are lost, so the source must watch the full flag
	assign fifo.push_valid = pix_rise && pval_s[1] && dual_en; // R3 R12
	assign fifo.push_data = pdat_s1;

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			PIX_FULL_O <= 1'b0;
		end else begin
			PIX_FULL_O <= !fifo.push_ready;
		end
	end

	// ==========================================
	// access scheduler: refresh reads beat writes, mode load only when idle
	assign go = state == ST_IDLE && mem_tick && dual_en; // R12 R13
	assign issue_mrs = go && mode_pend && sdram; // R9
	assign issue_rd = go && !issue_mrs && rd_pend;
	assign issue_wr = go && !issue_mrs && !rd_pend && fifo.pop_valid;
	assign fifo.pop_ready = issue_wr;
	assign cap_evt = (!sdram && edge_sel) ? mem_fall : mem_tick; // R7 R8
	assign capture = state == ST_RWAIT && cap_evt && wait_cnt == 2'h0;

	// a new request or load enable in the clearing cycle survives
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rd_pend <= 1'b0;
			mode_pend <= 1'b0;
		end else begin
			rd_pend <= RD_REQ_I || (rd_pend && !issue_rd);
			mode_pend <= (AV_WRITE_I && bus_acc && AV_ADDRESS_I == `DFB_OFF_FMC && AV_BYTEENABLE_I[0]
				&& AV_WRITEDATA_I[`DFB_FMC_MODE_LD]) || (mode_pend && !issue_mrs); // R9
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state <= ST_IDLE;
			wait_cnt <= 2'h0;
			MEM_RAS_N_O <= 1'b1;
			MEM_CAS_N_O <= 1'b1;
			MEM_WE_N_O <= 1'b1;
			MEM_ADDR_O <= '0;
			MEM_DQ_O <= '0;
			MEM_DQ_OE_O <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (issue_mrs) begin
						state <= ST_MRS;
						MEM_RAS_N_O <= 1'b0;
						MEM_CAS_N_O <= 1'b0;
						MEM_WE_N_O <= 1'b0;
						MEM_ADDR_O <= MODE_WORD; // R9
					end else if (issue_rd) begin
						state <= ST_READ;
						MEM_RAS_N_O <= sdram; // R11
						MEM_CAS_N_O <= 1'b0;
						MEM_ADDR_O <= rd_addr; // R1 R2
					end else if (issue_wr) begin
						state <= ST_WRITE;
						MEM_RAS_N_O <= sdram; // R11
						MEM_CAS_N_O <= 1'b0;
						MEM_WE_N_O <= 1'b0;
						MEM_ADDR_O <= wr_addr; // R1 R2
						MEM_DQ_O <= fifo.pop_data; // R3
						MEM_DQ_OE_O <= 1'b1;
					end
				end
				ST_MRS, ST_WRITE, ST_READ: begin
					if (mem_tick) begin
						MEM_RAS_N_O <= 1'b1;
						MEM_CAS_N_O <= 1'b1;
						MEM_WE_N_O <= 1'b1;
						MEM_DQ_OE_O <= 1'b0;
						state <= (state == ST_READ) ? ST_RWAIT : ST_IDLE; // R13
						wait_cnt <= sdram ? `DFB_CAS_LAT - 2'h1 : {1'b0, late}; // R6 R8
					end
				end
				ST_RWAIT: begin
					if (capture) begin
						state <= ST_IDLE;
					end else if (cap_evt) begin
						wait_cnt <= wait_cnt - 2'h1; // R6
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			wr_addr <= '0;
			rd_addr <= '0;
		end else begin
			if (issue_wr) begin
				wr_addr <= wrap_inc(wr_addr); // R2
			end
			if (issue_rd) begin
				rd_addr <= wrap_inc(rd_addr); // R3
			end
		end
	end

	// ==========================================
	// refresh data out
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			RD_DATA_O <= '0;
			RD_VALID_O <= 1'b0;
		end else begin
			RD_VALID_O <= capture; // R3
			if (capture) begin
				RD_DATA_O <= dq_s1;
			end
		end
	end

	// ==========================================
	// checks
	sequence s_read_end;
		state == ST_READ && mem_tick;
	endsequence
	sequence s_mrs_cmd;
		!MEM_RAS_N_O && !MEM_CAS_N_O && !MEM_WE_N_O && state == ST_MRS;
	endsequence

	property p_tick_full;
		!two_thirds && pix_rise |-> mem_tick;
	endproperty
	a_tick_full: assert property (p_tick_full) else $error("memory tick missed at full rate"); // R4

	property p_tick_drop;
		two_thirds && pix_rise && phase == `DFB_PHASE_LAST |-> !mem_tick;
	endproperty
	a_tick_drop: assert property (p_tick_drop) else $error("third tick not dropped"); // R4

	property p_late;
		s_read_end and (!sdram && late) |=> wait_cnt == 2'h1 && state == ST_RWAIT;
	endproperty
	a_late: assert property (p_late) else $error("late latch not delayed"); // R6

	property p_edge;
		capture && !sdram |-> (edge_sel ? mem_fall : mem_tick);
	endproperty
	a_edge: assert property (p_edge) else $error("edo capture on wrong edge"); // R7

	property p_sdram_ignore;
		s_read_end and sdram |=> wait_cnt == `DFB_CAS_LAT - 2'h1;
	endproperty
	a_sdram_ignore: assert property (p_sdram_ignore) else $error("edo settings leak into sdram"); // R8

	property p_mrs;
		issue_mrs |-> mode_pend && sdram ##1 s_mrs_cmd ##0 MEM_ADDR_O == MODE_WORD;
	endproperty
	a_mrs: assert property (p_mrs) else $error("mode load malformed"); // R9

	property p_clk_pol;
		$stable(clk_inv) |-> MEM_CLK_O == (mem_clk ^ clk_inv);
	endproperty
	a_clk_pol: assert property (p_clk_pol) else $error("sdram clock polarity wrong"); // R10

	property p_write_cmd;
		issue_wr |=> MEM_DQ_OE_O && !MEM_WE_N_O && MEM_RAS_N_O == sdram && MEM_DQ_O == $past(fifo.pop_data);
	endproperty
	a_write_cmd: assert property (p_write_cmd) else $error("write command wrong for type"); // R11

	property p_dual_off;
		!dual_en && state == ST_IDLE |=> state == ST_IDLE && !$past(fifo.push_valid);
	endproperty
	a_dual_off: assert property (p_dual_off) else $error("memory used outside dual-scan"); // R12

	property p_mrs_idle;
		state == ST_MRS && $past(state) != ST_MRS |-> $past(state) == ST_IDLE && !$past(rd_pend && !sdram);
	endproperty
	a_mrs_idle: assert property (p_mrs_idle) else $error("mode load during access"); // R13

	property p_readout;
		capture |=> RD_VALID_O && RD_DATA_O == $past(dq_s1) ##1 !RD_VALID_O;
	endproperty
	a_readout: assert property (p_readout) else $error("refresh data not presented"); // R3
endmodule

// ---- verilog/dfb_fifo.sv ----
`timescale 1ns/100ps
// depth must be a power of two: pointers wrap by overflow
module dfb_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// both sides
	dfb_fifo_if.store f
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wptr;
	logic [PW-1:0] rptr;
	logic [PW-1:0] next_rptr;
	logic [PW:0] count;
	logic [PW:0] next_count;
	logic push;
	logic pop;

	assign push = f.push_valid && f.push_ready;
	assign pop = f.pop_valid && f.pop_ready;
	assign next_rptr = pop ? rptr + 1'b1 : rptr;

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (!push && pop) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr] <= f.push_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			f.push_ready <= 1'b0;
			f.pop_valid <= 1'b0;
		end else begin
			wptr <= push ? wptr + 1'b1 : wptr;
			rptr <= next_rptr;
			count <= next_count;
			f.push_ready <= next_count != (PW+1)'(DEPTH);
			f.pop_valid <= next_count != '0;
		end
	end

	// read word is registered; bypass covers a write into the slot about to be shown
	always_ff @(posedge clk_i) begin
		f.pop_data <= (push && wptr == next_rptr) ? f.push_data : mem[next_rptr];
	end
endmodule
